//--- iopd_edge.sv
// per-pin edge detector and sticky status bit
`timescale 1ns/100ps
module iopd_edge (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic in_i,
   input wire logic [1:0] type_i,
   input wire logic clr_i,
   output logic stat_o
);
   import iopd_pkg::*;
   logic prev_reg;
   logic hit;
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         prev_reg <= 1'b0;
      end else begin
         prev_reg <= in_i;
      end
   end
   always_comb begin
      hit = 1'b0;
      case (type_i)
         IT_RISE: hit = in_i & ~prev_reg;
         IT_FALL: hit = ~in_i & prev_reg;
         IT_BOTH: hit = in_i ^ prev_reg;
         default: hit = 1'b0;
      endcase
   end
   // set wins over the read clear
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         stat_o <= 1'b0;
      end else if (hit) begin
         stat_o <= 1'b1;
      end else if (clr_i) begin
         stat_o <= 1'b0;
      end
   end
endmodule

//--- iopd_pads.sv
// external pad circuitry: contention, external drivers and a floating level
`timescale 1ns/100ps
module iopd_pads (
   input wire logic clk_i,
   input wire logic [7:0] hi_oe_b_i,
   input wire logic [7:0] lo_oe_b_i,
   input wire logic [7:0] hi_res_i,
   input wire logic [7:0] lo_res_i,
   input wire logic [7:0] ext_en_i,
   input wire logic [7:0] ext_val_i,
   output logic [7:0] pad_o
);
   logic [7:0] flt_reg = 8'h00;
   // undriven pad wanders every cycle
   always_ff @(posedge clk_i) begin
      flt_reg <= ~flt_reg;
   end
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (!hi_oe_b_i[i] && !hi_res_i[i])
            pad_o[i] = 1'h1;
         else if (!lo_oe_b_i[i] && !lo_res_i[i])
            pad_o[i] = 1'h0;
         else if (ext_en_i[i])
            pad_o[i] = ext_val_i[i];
         else if (!hi_oe_b_i[i])
            pad_o[i] = 1'h1;
         else if (!lo_oe_b_i[i])
            pad_o[i] = 1'h0;
         else
            pad_o[i] = flt_reg[i];
      end
   end
endmodule

//--- iopd_pkg.sv
// package of constants and types for the eight-pin port control block
package iopd_pkg;
   localparam int NPIN = 8;
   localparam int NOE = 16;
   localparam int OE_SEL_W = 4;
   // drive mode codes
   localparam logic [2:0] DM_HIZ_ANALOG = 3'h0;
   localparam logic [2:0] DM_HIZ_DIGITAL = 3'h1;
   localparam logic [2:0] DM_RES_PULLUP = 3'h2;
   localparam logic [2:0] DM_RES_PULLDOWN = 3'h3;
   localparam logic [2:0] DM_OD_LOW = 3'h4;
   localparam logic [2:0] DM_OD_HIGH = 3'h5;
   localparam logic [2:0] DM_STRONG = 3'h6;
   localparam logic [2:0] DM_RES_BOTH = 3'h7;
   localparam logic [2:0] DM_RESET = DM_HIZ_ANALOG;
   // interrupt type codes
   localparam logic [1:0] IT_NONE = 2'h0;
   localparam logic [1:0] IT_RISE = 2'h1;
   localparam logic [1:0] IT_FALL = 2'h2;
   localparam logic [1:0] IT_BOTH = 2'h3;
   // pin-form register layout
   localparam int PF_OUT = 0;
   localparam int PF_DM_LO = 1;
   localparam int PF_DM_HI = 3;
   localparam int PF_BYP = 4;
   localparam int PF_BIE = 5;
   localparam int PF_SLW = 6;
   localparam int PF_IBD = 7;
   // port register selects
   localparam logic [3:0] PR_OUT = 4'h0;
   localparam logic [3:0] PR_DM0 = 4'h1;
   localparam logic [3:0] PR_DM1 = 4'h2;
   localparam logic [3:0] PR_DM2 = 4'h3;
   localparam logic [3:0] PR_SLW = 4'h4;
   localparam logic [3:0] PR_BYP = 4'h5;
   localparam logic [3:0] PR_BIE = 4'h6;
   localparam logic [3:0] PR_IBD = 4'h7;
   localparam logic [3:0] PR_ITLO = 4'h8;
   localparam logic [3:0] PR_ITHI = 4'h9;
   localparam logic [3:0] PR_STAT = 4'ha;
   localparam logic [3:0] PR_PINS = 4'hb;
   localparam logic [3:0] PR_REGO = 4'hc;
   localparam logic [3:0] PR_PAIR = 4'hd;
   localparam logic [3:0] PR_MISC = 4'he;
   // pad drive strength codes
   typedef enum logic [1:0] {
      DRV_OFF = 2'b00,
      DRV_STRONG = 2'b01,
      DRV_RES = 2'b10
   } iopd_drv_t;
endpackage

//--- iopd_port.sv
// eight-pin port: drive modes, port and pin form registers, edge interrupts
`timescale 1ns/100ps
module iopd_port (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // port-form access
   input wire logic port_wr_i,
   input wire logic port_rd_i,
   input wire logic [3:0] port_sel_i,
   input wire logic [7:0] port_wdata_i,
   output logic [7:0] port_rdata_o,
   // pin-form access
   input wire logic pin_wr_i,
   input wire logic pin_rd_i,
   input wire logic [2:0] pin_sel_i,
   input wire logic [7:0] pin_wdata_i,
   output logic [7:0] pin_rdata_o,
   // digital system side
   input wire logic [iopd_pkg::NPIN-1:0] bypass_data_i,
   input wire logic [iopd_pkg::NOE-1:0] aux_oe_i,
   output logic [iopd_pkg::NPIN-1:0] sys_in_o,
   output logic irq_o,
   // pad side
   input wire logic [iopd_pkg::NPIN-1:0] pad_in_i,
   output logic [iopd_pkg::NPIN-1:0] pad_hi_oe_b_o,
   output logic [iopd_pkg::NPIN-1:0] pad_lo_oe_b_o,
   output logic [iopd_pkg::NPIN-1:0] pad_hi_res_o,
   output logic [iopd_pkg::NPIN-1:0] pad_lo_res_o,
   output logic [iopd_pkg::NPIN-1:0] pad_ibuf_en_o,
   output logic [iopd_pkg::NPIN-1:0] pad_slow_o,
   output logic [iopd_pkg::NPIN-1:0] pad_reg_hi_o,
   output logic [7:0] pad_pair_thr_o,
   output logic pad_lvttl_o
);
   import iopd_pkg::*;
   logic [7:0] port_output_value_reg;
   logic [7:0] drive_mode_bit0_reg;
   logic [7:0] drive_mode_bit1_reg;
   logic [7:0] drive_mode_bit2_reg;
   logic [7:0] port_slew_select_reg;
   logic [7:0] bypass_sel_reg;
   logic [7:0] bidir_en_reg;
   logic [7:0] ibuf_dis_reg;
   logic [7:0] int_type_lo_reg;
   logic [7:0] int_type_hi_reg;
   logic [7:0] reg_hi_sel_reg;
   logic [7:0] pair_thr_reg;
   logic [7:0] misc_reg;
   logic [31:0] oe_route_reg;
   logic [7:0] sync1_reg;
   logic [7:0] sync2_reg;
   logic [7:0] sync3_reg;
   logic [7:0] in_reg;
   logic [7:0] stat;
   logic stat_clr;
   logic [7:0] port_rdata_next;
   logic [7:0] pin_rdata_next;
   logic [7:0] pin_mask;

   // drive mode of pin n, one bit from each of the three mode bit registers
   function automatic logic [2:0] mode_of(input int n, input logic [7:0] b0,
         input logic [7:0] b1, input logic [7:0] b2);
      mode_of = {b2[n], b1[n], b0[n]};
   endfunction

   assign pin_mask = 8'h01 << pin_sel_i;

   // shared storage written from either form
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         port_output_value_reg <= 8'h00;
         drive_mode_bit0_reg <= {8{DM_RESET[0]}};
         drive_mode_bit1_reg <= {8{DM_RESET[1]}};
         drive_mode_bit2_reg <= {8{DM_RESET[2]}};
         port_slew_select_reg <= 8'h00;
         bypass_sel_reg <= 8'h00;
         bidir_en_reg <= 8'h00;
         ibuf_dis_reg <= 8'h00;
      end else if (pin_wr_i) begin
         port_output_value_reg <= (port_output_value_reg & ~pin_mask)
            | ({8{pin_wdata_i[PF_OUT]}} & pin_mask);
         drive_mode_bit0_reg <= (drive_mode_bit0_reg & ~pin_mask)
            | ({8{pin_wdata_i[PF_DM_LO]}} & pin_mask);
         drive_mode_bit1_reg <= (drive_mode_bit1_reg & ~pin_mask)
            | ({8{pin_wdata_i[PF_DM_LO+1]}} & pin_mask);
         drive_mode_bit2_reg <= (drive_mode_bit2_reg & ~pin_mask)
            | ({8{pin_wdata_i[PF_DM_HI]}} & pin_mask);
         bypass_sel_reg <= (bypass_sel_reg & ~pin_mask)
            | ({8{pin_wdata_i[PF_BYP]}} & pin_mask);
         bidir_en_reg <= (bidir_en_reg & ~pin_mask)
            | ({8{pin_wdata_i[PF_BIE]}} & pin_mask);
         port_slew_select_reg <= (port_slew_select_reg & ~pin_mask)
            | ({8{pin_wdata_i[PF_SLW]}} & pin_mask);
         ibuf_dis_reg <= (ibuf_dis_reg & ~pin_mask)
            | ({8{pin_wdata_i[PF_IBD]}} & pin_mask);
      end else if (port_wr_i) begin
         if (port_sel_i == PR_OUT) begin
            port_output_value_reg <= port_wdata_i;
         end else if (port_sel_i == PR_DM0) begin
            drive_mode_bit0_reg <= port_wdata_i;
         end else if (port_sel_i == PR_DM1) begin
            drive_mode_bit1_reg <= port_wdata_i;
         end else if (port_sel_i == PR_DM2) begin
            drive_mode_bit2_reg <= port_wdata_i;
         end else if (port_sel_i == PR_SLW) begin
            port_slew_select_reg <= port_wdata_i;
         end else if (port_sel_i == PR_BYP) begin
            bypass_sel_reg <= port_wdata_i;
         end else if (port_sel_i == PR_BIE) begin
            bidir_en_reg <= port_wdata_i;
         end else if (port_sel_i == PR_IBD) begin
            ibuf_dis_reg <= port_wdata_i;
         end
      end
   end

   // port-only settings
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         int_type_lo_reg <= 8'h00;
         int_type_hi_reg <= 8'h00;
         reg_hi_sel_reg <= 8'h00;
         pair_thr_reg <= 8'h00;
         misc_reg <= 8'h00;
      end else if (port_wr_i && !pin_wr_i) begin
         if (port_sel_i == PR_ITLO) begin
            int_type_lo_reg <= port_wdata_i;
         end else if (port_sel_i == PR_ITHI) begin
            int_type_hi_reg <= port_wdata_i;
         end else if (port_sel_i == PR_REGO) begin
            reg_hi_sel_reg <= port_wdata_i;
         end else if (port_sel_i == PR_PAIR) begin
            pair_thr_reg <= port_wdata_i;
         end else if (port_sel_i == PR_MISC) begin
            misc_reg <= port_wdata_i;
         end
      end
   end

   // output-enable routing: 4-bit selector per pin, one write per pin pair
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         oe_route_reg <= 32'h00000000;
      end else if (port_wr_i && !pin_wr_i && port_sel_i == 4'hf) begin
         oe_route_reg[{misc_reg[7:6], 3'h0} +: 8] <= port_wdata_i;
      end
   end

   // pad input synchroniser
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sync1_reg <= 8'h00;
         sync2_reg <= 8'h00;
         sync3_reg <= 8'h00;
         in_reg <= 8'h00;
      end else begin
         sync1_reg <= pad_in_i;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         for (int i = 0; i < NPIN; i++) begin
            if (sync2_reg[i] == sync3_reg[i]) begin
               in_reg[i] <= sync3_reg[i];
            end
         end
      end
   end

   // pad drive decode
   always_comb begin
      logic [2:0] dm;
      logic d;
      logic oe;
      logic [2:0] eff;
      iopd_drv_t hi;
      iopd_drv_t lo;
      dm = 3'h0;
      d = 1'b0;
      oe = 1'b0;
      eff = 3'h0;
      hi = DRV_OFF;
      lo = DRV_OFF;
      for (int i = 0; i < NPIN; i++) begin
         dm = mode_of(i, drive_mode_bit0_reg, drive_mode_bit1_reg, drive_mode_bit2_reg);
         d = bypass_sel_reg[i] ? bypass_data_i[i] : port_output_value_reg[i];
         oe = aux_oe_i[oe_route_reg[i*OE_SEL_W +: OE_SEL_W]];
         eff = (bidir_en_reg[i] && !oe) ? DM_HIZ_DIGITAL : dm;
         hi = DRV_OFF;
         lo = DRV_OFF;
         case (eff)
            DM_HIZ_ANALOG: hi = DRV_OFF;
            DM_HIZ_DIGITAL: hi = DRV_OFF;
            DM_RES_PULLUP: begin
               hi = d ? DRV_RES : DRV_OFF;
               lo = d ? DRV_OFF : DRV_STRONG;
            end
            DM_RES_PULLDOWN: begin
               hi = d ? DRV_STRONG : DRV_OFF;
               lo = d ? DRV_OFF : DRV_RES;
            end
            DM_OD_LOW: lo = d ? DRV_OFF : DRV_STRONG;
            DM_OD_HIGH: hi = d ? DRV_STRONG : DRV_OFF;
            DM_STRONG: begin
               hi = d ? DRV_STRONG : DRV_OFF;
               lo = d ? DRV_OFF : DRV_STRONG;
            end
            default: begin
               hi = d ? DRV_RES : DRV_OFF;
               lo = d ? DRV_OFF : DRV_RES;
            end
         endcase
         pad_hi_oe_b_o[i] = (hi == DRV_OFF);
         pad_lo_oe_b_o[i] = (lo == DRV_OFF);
         pad_hi_res_o[i] = (hi == DRV_RES);
         pad_lo_res_o[i] = (lo == DRV_RES);
         pad_ibuf_en_o[i] = (dm != DM_HIZ_ANALOG) && !ibuf_dis_reg[i];
         pad_slow_o[i] = port_slew_select_reg[i] && (hi != DRV_RES) && (lo != DRV_RES);
      end
   end

   assign pad_reg_hi_o = reg_hi_sel_reg;
   assign pad_pair_thr_o = pair_thr_reg;
   assign pad_lvttl_o = misc_reg[0];
   assign sys_in_o = in_reg & pad_ibuf_en_o;

   // edge detection on plain clock, never gated by sleep
   genvar g;
   generate
      for (g = 0; g < NPIN; g++) begin : g_edge
         iopd_edge u_edge (
            .mclk_i(mclk_i),
            .rst_b_i(rst_b_i),
            .in_i(sys_in_o[g]),
            .type_i(g < 4 ? int_type_lo_reg[2*(g%4) +: 2] : int_type_hi_reg[2*(g%4) +: 2]),
            .clr_i(stat_clr),
            .stat_o(stat[g])
         );
      end
   endgenerate

   assign stat_clr = port_rd_i && (port_sel_i == PR_STAT);
   assign irq_o = |stat;

   // registered read data
   always_comb begin
      port_rdata_next = 8'h00;
      if (port_sel_i == PR_OUT) begin
         port_rdata_next = port_output_value_reg;
      end else if (port_sel_i == PR_DM0) begin
         port_rdata_next = drive_mode_bit0_reg;
      end else if (port_sel_i == PR_DM1) begin
         port_rdata_next = drive_mode_bit1_reg;
      end else if (port_sel_i == PR_DM2) begin
         port_rdata_next = drive_mode_bit2_reg;
      end else if (port_sel_i == PR_SLW) begin
         port_rdata_next = port_slew_select_reg;
      end else if (port_sel_i == PR_BYP) begin
         port_rdata_next = bypass_sel_reg;
      end else if (port_sel_i == PR_BIE) begin
         port_rdata_next = bidir_en_reg;
      end else if (port_sel_i == PR_IBD) begin
         port_rdata_next = ibuf_dis_reg;
      end else if (port_sel_i == PR_ITLO) begin
         port_rdata_next = int_type_lo_reg;
      end else if (port_sel_i == PR_ITHI) begin
         port_rdata_next = int_type_hi_reg;
      end else if (port_sel_i == PR_STAT) begin
         port_rdata_next = stat;
      end else if (port_sel_i == PR_PINS) begin
         port_rdata_next = sys_in_o;
      end else if (port_sel_i == PR_REGO) begin
         port_rdata_next = reg_hi_sel_reg;
      end else if (port_sel_i == PR_PAIR) begin
         port_rdata_next = pair_thr_reg;
      end else if (port_sel_i == PR_MISC) begin
         port_rdata_next = misc_reg;
      end else begin
         port_rdata_next = oe_route_reg[{misc_reg[7:6], 3'h0} +: 8];
      end
      pin_rdata_next = {ibuf_dis_reg[pin_sel_i], port_slew_select_reg[pin_sel_i],
         bidir_en_reg[pin_sel_i], bypass_sel_reg[pin_sel_i],
         drive_mode_bit2_reg[pin_sel_i], drive_mode_bit1_reg[pin_sel_i],
         drive_mode_bit0_reg[pin_sel_i], port_output_value_reg[pin_sel_i]};
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         port_rdata_o <= 8'h00;
         pin_rdata_o <= 8'h00;
      end else begin
         if (port_rd_i) begin
            port_rdata_o <= port_rdata_next;
         end
         if (pin_rd_i) begin
            pin_rdata_o <= pin_rdata_next;
         end
      end
   end
endmodule

//--- iopd_port_monitor.sv
// concurrent checks on the eight-pin port block
`timescale 1ns/100ps
module iopd_port_check (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic port_wr_i,
   input wire logic pin_wr_i,
   input wire logic port_rd_i,
   input wire logic [3:0] port_sel_i,
   input wire logic [7:0] port_wdata_i,
   input wire logic [7:0] port_rdata_o,
   input wire logic pin_rd_i,
   input wire logic [7:0] pin_rdata_o,
   input wire logic [7:0] pad_in_i,
   input wire logic [7:0] sys_in_o,
   input wire logic irq_o,
   input wire logic [7:0] pad_hi_oe_b_o,
   input wire logic [7:0] pad_lo_oe_b_o,
   input wire logic [7:0] pad_hi_res_o,
   input wire logic [7:0] pad_lo_res_o,
   input wire logic [7:0] pad_ibuf_en_o,
   input wire logic [7:0] pad_slow_o,
   input wire logic [7:0] pad_reg_hi_o,
   input wire logic [7:0] pad_pair_thr_o,
   input wire logic pad_lvttl_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);
   logic wr_ok;
   assign wr_ok = port_wr_i & ~pin_wr_i;
   property p_reset_hiz;
      $rose(rst_b_i) |-> (&pad_hi_oe_b_o) && (&pad_lo_oe_b_o) && !irq_o;
   endproperty
   a_reset_hiz: assert property (p_reset_hiz)
      else $error("pad driven after reset");
   property p_one_side;
      (pad_hi_oe_b_o | pad_lo_oe_b_o) == 8'hff;
   endproperty
   a_one_side: assert property (p_one_side)
      else $error("both drivers on");
   property p_ibuf_gate;
      wr_ok && port_sel_i == 4'h7 |=> ((pad_ibuf_en_o | sys_in_o) & $past(port_wdata_i)) == 8'h00;
   endproperty
   a_ibuf_gate: assert property (p_ibuf_gate)
      else $error("input seen with buffer off");
   property p_slew;
      (pad_slow_o & ((~pad_hi_oe_b_o & pad_hi_res_o) | (~pad_lo_oe_b_o & pad_lo_res_o))) == 8'h00;
   endproperty
   a_slew: assert property (p_slew)
      else $error("slow slew on resistive drive");
   property p_rdata_hold;
      !port_rd_i |=> $stable(port_rdata_o);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("port read data moved");
   property p_pin_hold;
      !pin_rd_i |=> $stable(pin_rdata_o);
   endproperty
   a_pin_hold: assert property (p_pin_hold)
      else $error("pin read data moved");
   property p_stat_read;
      port_rd_i && port_sel_i == 4'ha |=> (port_rdata_o != 8'h00) == $past(irq_o);
   endproperty
   a_stat_read: assert property (p_stat_read)
      else $error("request does not match status");
   property p_stat_clear;
      ($stable(pad_in_i) && $stable(pad_ibuf_en_o)) [*6] ##0 (port_rd_i && port_sel_i == 4'ha)
         |=> !irq_o;
   endproperty
   a_stat_clear: assert property (p_stat_clear)
      else $error("request stays after status read");
   property p_lvttl;
      wr_ok && port_sel_i == 4'he |=> {7'h00, pad_lvttl_o} == ($past(port_wdata_i) & 8'h01);
   endproperty
   a_lvttl: assert property (p_lvttl)
      else $error("threshold select not taken");
   property p_reg_hi;
      wr_ok && port_sel_i == 4'hc |=> pad_reg_hi_o == $past(port_wdata_i);
   endproperty
   a_reg_hi: assert property (p_reg_hi)
      else $error("regulated high select not taken");
   property p_pair;
      wr_ok && port_sel_i == 4'hd |=> pad_pair_thr_o == $past(port_wdata_i);
   endproperty
   a_pair: assert property (p_pair)
      else $error("pair threshold not taken");
endmodule
bind iopd_port iopd_port_check u_chk (.mclk_i, .rst_b_i, .port_wr_i, .pin_wr_i, .port_rd_i,
   .port_sel_i, .port_wdata_i, .port_rdata_o, .pin_rd_i, .pin_rdata_o, .pad_in_i, .sys_in_o,
   .irq_o, .pad_hi_oe_b_o, .pad_lo_oe_b_o, .pad_hi_res_o, .pad_lo_res_o, .pad_ibuf_en_o,
   .pad_slow_o, .pad_reg_hi_o, .pad_pair_thr_o, .pad_lvttl_o);

//--- testbench.sv
// self-checking testbench for the eight-pin port block
`timescale 1ns/100ps
module testbench;
   import iopd_pkg::*;
   logic mclk_i = 1'h0;
   logic rst_b_i = 1'h0;
   logic port_wr_i = 1'h0;
   logic port_rd_i = 1'h0;
   logic pin_wr_i = 1'h0;
   logic pin_rd_i = 1'h0;
   logic [3:0] port_sel_i = 4'h0;
   logic [2:0] pin_sel_i = 3'h0;
   logic [7:0] port_wdata_i = 8'h00;
   logic [7:0] pin_wdata_i = 8'h00;
   logic [7:0] bypass_data_i = 8'h00;
   logic [7:0] ext_val = 8'h00;
   logic [7:0] ext_en = 8'hff;
   logic [15:0] aux_oe_i = 16'h0000;
   logic [7:0] rd_val, port_rdata_o, pin_rdata_o, sys_in_o, pad_in_i, pad_hi_oe_b_o;
   logic [7:0] pad_lo_oe_b_o, pad_hi_res_o, pad_lo_res_o, pad_ibuf_en_o, pad_slow_o;
   logic [7:0] pad_reg_hi_o, pad_pair_thr_o;
   logic irq_o, pad_lvttl_o;
   int num_errors = 0;
   int comparisons = 0;
   iopd_port uut (.mclk_i, .rst_b_i, .port_wr_i, .port_rd_i, .port_sel_i, .port_wdata_i,
      .port_rdata_o, .pin_wr_i, .pin_rd_i, .pin_sel_i, .pin_wdata_i, .pin_rdata_o,
      .bypass_data_i, .aux_oe_i, .sys_in_o, .irq_o, .pad_in_i, .pad_hi_oe_b_o, .pad_lo_oe_b_o,
      .pad_hi_res_o, .pad_lo_res_o, .pad_ibuf_en_o, .pad_slow_o, .pad_reg_hi_o,
      .pad_pair_thr_o, .pad_lvttl_o);
   iopd_pads u_pads (.clk_i(mclk_i), .hi_oe_b_i(pad_hi_oe_b_o), .lo_oe_b_i(pad_lo_oe_b_o),
      .hi_res_i(pad_hi_res_o), .lo_res_i(pad_lo_res_o), .ext_en_i(ext_en),
      .ext_val_i(ext_val), .pad_o(pad_in_i));
   initial begin
      forever #12.5 mclk_i = ~mclk_i;
   end
   task automatic finish_test;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic pw(input logic [3:0] s, input logic [7:0] d);
      @(negedge mclk_i);
      port_wr_i = 1'h1;
      port_sel_i = s;
      port_wdata_i = d;
      @(negedge mclk_i);
      port_wr_i = 1'h0;
   endtask
   task automatic pr(input logic [3:0] s);
      @(negedge mclk_i);
      port_rd_i = 1'h1;
      port_sel_i = s;
      @(negedge mclk_i);
      port_rd_i = 1'h0;
      rd_val = port_rdata_o;
   endtask
   task automatic pinw(input logic [2:0] p, input logic [7:0] d);
      @(negedge mclk_i);
      pin_wr_i = 1'h1;
      pin_sel_i = p;
      pin_wdata_i = d;
      @(negedge mclk_i);
      pin_wr_i = 1'h0;
   endtask
   task automatic pinr(input logic [2:0] p);
      @(negedge mclk_i);
      pin_rd_i = 1'h1;
      pin_sel_i = p;
      @(negedge mclk_i);
      pin_rd_i = 1'h0;
      rd_val = pin_rdata_o;
   endtask
   task automatic wait_irq;
      int i;
      for (i = 0; i < 20 && irq_o !== 1'h1; i++)
         @(negedge mclk_i);
      if (i == 20) begin
         num_errors++;
         $display("CHECK FAILED at %0t: no request", $time);
         finish_test();
      end
      repeat (4) @(negedge mclk_i);
   endtask
   // {high on, high resistive, low on, low resistive}
   function automatic logic [3:0] drv(input logic [2:0] m, input logic d);
      case (m)
         3'h2: return d ? 4'hc : 4'h2;
         3'h3: return d ? 4'h8 : 4'h3;
         3'h4: return d ? 4'h0 : 4'h2;
         3'h5: return d ? 4'h8 : 4'h0;
         3'h6: return d ? 4'h8 : 4'h2;
         3'h7: return d ? 4'hc : 4'h3;
         default: return 4'h0;
      endcase
   endfunction
   task automatic t_reset;
      chk(pad_hi_oe_b_o & pad_lo_oe_b_o, 8'hff);
      chk(pad_ibuf_en_o, 8'h00);
      chk(irq_o, 1'h0);
      pr(PR_DM2);
      chk(rd_val, 8'h00);
   endtask
   task automatic t_modes;
      logic [3:0] e;
      pw(PR_SLW, 8'hff);
      for (int m = 0; m < 8; m++) begin
         for (int d = 0; d < 2; d++) begin
            pw(PR_DM0, {8{m[0]}});
            pw(PR_DM1, {8{m[1]}});
            pw(PR_DM2, {8{m[2]}});
            pw(PR_OUT, {8{d[0]}});
            e = drv(m[2:0], d[0]);
            chk(pad_hi_oe_b_o, {8{~e[3]}});
            chk(pad_hi_res_o & ~pad_hi_oe_b_o, {8{e[2]}});
            chk(pad_lo_oe_b_o, {8{~e[1]}});
            chk(pad_lo_res_o & ~pad_lo_oe_b_o, {8{e[0]}});
            chk(pad_ibuf_en_o, {8{m != 0}});
            if (m > 3)
               chk(pad_slow_o, {8{m != 7}});
         end
      end
      pw(PR_SLW, 8'h00);
   endtask
   task automatic t_pin;
      pw(PR_DM0, 8'h00);
      pw(PR_DM1, 8'h00);
      pw(PR_DM2, 8'h00);
      pw(PR_OUT, 8'h00);
      pinw(3'h3, 8'h4d);
      chk(pad_hi_oe_b_o, 8'hf7);
      pr(PR_DM1);
      chk(rd_val, 8'h08);
      pr(PR_SLW);
      chk(rd_val, 8'h08);
      pw(PR_DM0, 8'h08);
      pinr(3'h3);
      chk(rd_val, 8'h4f);
      pinw(3'h3, 8'h1c);
      bypass_data_i = 8'h08;
      @(negedge mclk_i);
      chk(pad_hi_oe_b_o, 8'hf7);
      bypass_data_i = 8'h00;
      @(negedge mclk_i);
      chk(pad_lo_oe_b_o, 8'hf7);
   endtask
   task automatic t_bidir;
      pinw(3'h3, 8'h2c);
      pw(PR_MISC, 8'h40);
      for (int s = 0; s < 16; s++) begin
         pw(4'hf, {s[3:0], 4'h0});
         aux_oe_i = 16'h0001 << s;
         @(negedge mclk_i);
         chk(pad_lo_oe_b_o, 8'hf7);
         aux_oe_i = ~(16'h0001 << s);
         @(negedge mclk_i);
         chk(pad_lo_oe_b_o, 8'hff);
         chk(pad_ibuf_en_o[3], 1'h1);
      end
   endtask
   task automatic t_thr;
      pw(PR_MISC, 8'h01);
      chk(pad_lvttl_o, 1'h1);
      pw(PR_REGO, 8'ha5);
      chk(pad_reg_hi_o, 8'ha5);
      pw(PR_PAIR, 8'h1b);
      chk(pad_pair_thr_o, 8'h1b);
      pw(PR_IBD, 8'h08);
      chk(pad_ibuf_en_o[3], 1'h0);
      chk(sys_in_o[3], 1'h0);
      pw(PR_IBD, 8'h00);
      pw(PR_MISC, 8'h00);
   endtask
   task automatic t_irq;
      pw(PR_DM0, 8'hff);
      pw(PR_DM1, 8'h00);
      pw(PR_DM2, 8'h00);
      pw(PR_BIE, 8'h00);
      pw(PR_BYP, 8'h00);
      repeat (8) @(negedge mclk_i);
      pr(PR_STAT);
      // pin4 rise
      pw(PR_ITHI, 8'h01);
      // pin0 none, pin1 rise, pin2 fall, pin3 both
      pw(PR_ITLO, 8'he4);
      ext_val = 8'hff;
      wait_irq();
      chk(sys_in_o, 8'hff);
      pr(PR_PINS);
      chk(rd_val, 8'hff);
      pr(PR_STAT);
      chk(rd_val, 8'h1a);
      chk(irq_o, 1'h0);
      ext_val = 8'h00;
      wait_irq();
      pr(PR_STAT);
      chk(rd_val, 8'h0c);
      pw(PR_ITLO, 8'h00);
      pw(PR_ITHI, 8'h00);
   endtask
   // released pads: a wandering level never passes the filter, strong high and resistive low drive are read back
   task automatic t_float;
      ext_en = 8'h00;
      repeat (8) @(negedge mclk_i);
      chk(sys_in_o, 8'h00);
      pw(PR_DM1, 8'hff);
      pw(PR_OUT, 8'hff);
      repeat (5) @(negedge mclk_i);
      chk(sys_in_o, 8'hff);
      pw(PR_OUT, 8'h00);
      repeat (5) @(negedge mclk_i);
      chk(sys_in_o, 8'h00);
      ext_en = 8'hff;
      pw(PR_DM1, 8'h00);
   endtask
   initial begin
      repeat (8) @(negedge mclk_i);
      rst_b_i = 1'h1;
      t_reset();
      t_modes();
      t_pin();
      t_bidir();
      t_thr();
      t_irq();
      t_float();
      finish_test();
   end
endmodule
